// *** logic/bank_arb_consts.svh ***
// Constants for the second-level RAM bank arbiter
// Contract
// [RULE1] Same bank clash: core wins, engine waits
// [RULE2] Four banks, 64-bit units interleaved
// [RULE3] Different banks: both granted same cycle
// [RULE4] Up to two core stores per cycle
// [RULE5] Any store cycle occupies its bank
// [RULE6] Store elsewhere frees waiting bank
// [RULE7] Split parallel stores never lock engine
// [RULE8] RAM-reaching load opens engine gap
// [RULE9] Load gap holds even beside stores
// [RULE10] Word stride of eight hits same bank
// [RULE11] Control bit prevents store starvation; here fair_en instead gives the waiting engine a turn over the stores
// [RULE12] Losing engine request stays pending, retried
`ifndef BANK_ARB_CONSTS_SVH
`define BANK_ARB_CONSTS_SVH
// ==========================================
// Address decode
`define BANK_COUNT     4
`define BANK_SEL_LSB   3
`define BANK_SEL_WIDTH 2
// ==========================================
// Fairness
`define FAIR_LIMIT     4'h4
`define WAIT_MAX       4'hF
`define WAIT_RESET     4'h0
`endif

// *** logic/bank_arb_pkg.sv ***
// Types for the second-level RAM bank arbiter
package bank_arb_pkg;
  // One RAM request: valid plus byte address
  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
  } ram_req_t;
  // Engine wait guard states
  typedef enum logic [1:0] {
    ARB_IDLE,
    ARB_WAIT,
    ARB_TURN
  } arb_state_t;
endpackage

// *** logic/l2_bank_conflict_arbiter.sv ***
// Bank arbiter between core data side and transfer engine
`timescale 1ns/1ps
`include "bank_arb_consts.svh"

// ==========================================
// Bank decode of one core requester
module bank_hit #(
  parameter int SEL_LSB   = `BANK_SEL_LSB,
  parameter int SEL_WIDTH = `BANK_SEL_WIDTH
) (
  // Requester and engine bank
  input  wire bank_arb_pkg::ram_req_t req,
  input  wire logic [SEL_WIDTH-1:0]   dma_bank,
  // Decode results
  output logic [SEL_WIDTH-1:0]        bank,
  output logic                        hit,
  output logic                        miss
);
  // Bank from the 64-bit unit number
  assign bank = req.addr[SEL_LSB +: SEL_WIDTH]; // RULE2
  // Same bank as the engine, or a live request elsewhere
  assign hit  = req.valid && (bank == dma_bank); // RULE5
  assign miss = req.valid && (bank != dma_bank); // RULE6
endmodule

// ==========================================
// Arbiter top
module l2_bank_conflict_arbiter #(
  parameter logic [3:0] FAIR_LIMIT = `FAIR_LIMIT,
  parameter int         BANK_COUNT = `BANK_COUNT,
  parameter int         SEL_LSB    = `BANK_SEL_LSB,
  parameter int         SEL_WIDTH  = `BANK_SEL_WIDTH
) (
  // Clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  // Core stores, up to two per cycle
  input  wire bank_arb_pkg::ram_req_t store_a,
  input  wire bank_arb_pkg::ram_req_t store_b,
  // Core load that missed the first_level_data_cache
  input  wire bank_arb_pkg::ram_req_t load_req,
  // Transfer engine request
  input  wire bank_arb_pkg::ram_req_t dma_req,
  // Starvation guard enable
  input  wire logic                   fair_en,
  // Grants
  output logic                        store_a_gnt,
  output logic                        store_b_gnt,
  output logic                        load_gnt,
  output logic                        dma_gnt,
  output logic                        dma_pending
);

  // ==========================================
  // Local signals
  // Bank numbers
  logic [SEL_WIDTH-1:0]     bank_sa;
  logic [SEL_WIDTH-1:0]     bank_sb;
  logic [SEL_WIDTH-1:0]     bank_ld;
  logic [SEL_WIDTH-1:0]     bank_dm;

  // Hits on the engine's bank and live requests elsewhere
  logic                     hit_a;
  logic                     hit_b;
  logic                     hit_ld;
  logic                     miss_a;
  logic                     miss_b;

  // Per-bank occupancy
  wire [BANK_COUNT-1:0]     core_busy;
  wire [BANK_COUNT-1:0]     dma_want;
  wire [BANK_COUNT-1:0]     bank_clash;

  // Arbitration terms
  logic                     clash;
  logic                     other_st;
  logic                     gap;
  logic                     starve;
  logic                     dma_win;

  // Starvation guard
  logic [3:0]               wait_q;
  logic [3:0]               wait_d;
  logic [3:0]               wait_inc;
  logic                     limit_hit;
  bank_arb_pkg::arb_state_t state_q;
  bank_arb_pkg::arb_state_t state_d;

  // ==========================================
  // Engine bank
  // Engine bank straight from its own address
  assign bank_dm = dma_req.addr[SEL_LSB +: SEL_WIDTH]; // RULE10

  // ==========================================
  // Core requester decode
  // Store port A
  bank_hit #(
    .SEL_LSB   (SEL_LSB),
    .SEL_WIDTH (SEL_WIDTH)
  ) u_hit_sa (
    .req      (store_a),
    .dma_bank (bank_dm),
    .bank     (bank_sa),
    .hit      (hit_a),
    .miss     (miss_a)
  );

  // Store port B, a second store in the same cycle
  bank_hit #(
    .SEL_LSB   (SEL_LSB),
    .SEL_WIDTH (SEL_WIDTH)
  ) u_hit_sb (
    .req      (store_b),
    .dma_bank (bank_dm),
    .bank     (bank_sb),
    .hit      (hit_b),
    .miss     (miss_b)
  );

  // Load port, any bank opens a gap so its miss is not needed
  bank_hit #(
    .SEL_LSB   (SEL_LSB),
    .SEL_WIDTH (SEL_WIDTH)
  ) u_hit_ld (
    .req      (load_req),
    .dma_bank (bank_dm),
    .bank     (bank_ld),
    .hit      (hit_ld),
    .miss     ()
  );

  // ==========================================
  // Bank occupancy
  // Core use and engine wish per bank, clash where both meet
  for (genvar b = 0; b < BANK_COUNT; b++) begin : g_bank
    assign core_busy[b]  = (store_a.valid && (bank_sa == SEL_WIDTH'(b)))
                        || (store_b.valid && (bank_sb == SEL_WIDTH'(b)))
                        || (load_req.valid && (bank_ld == SEL_WIDTH'(b))); // RULE5
    assign dma_want[b]   = dma_req.valid && (bank_dm == SEL_WIDTH'(b));
    assign bank_clash[b] = core_busy[b] && dma_want[b];
  end
  // Any bank claimed by both sides
  assign clash = |bank_clash;

  // ==========================================
  // Gap and guard
  // A store elsewhere or any RAM-reaching load frees the waiting bank
  assign other_st = miss_a || miss_b; // RULE6 RULE7
  assign gap      = load_req.valid || other_st; // RULE8 RULE9
  // Guard turn once the engine has waited its limit
  assign starve   = fair_en && (state_q == bank_arb_pkg::ARB_TURN); // RULE11
  // Engine wins on a clean bank, a gap, or a guard turn
  assign dma_win  = dma_req.valid && (!clash || gap || starve); // RULE1 RULE3

  // ==========================================
  // Grants
  // Core keeps priority unless the engine takes its bank
  assign dma_gnt     = dma_win;
  assign store_a_gnt = store_a.valid && !(dma_win && hit_a); // RULE1
  assign store_b_gnt = store_b.valid && !(dma_win && hit_b); // RULE4
  assign load_gnt    = load_req.valid && !(dma_win && hit_ld);
  assign dma_pending = dma_req.valid && !dma_win; // RULE12

  // ==========================================
  // Starvation guard
  // Saturating count of cycles the engine has lost
  assign wait_inc  = 4'(wait_q + 4'h1);
  assign wait_d    = !dma_pending          ? `WAIT_RESET
                   : (wait_q == `WAIT_MAX) ? wait_q
                   : wait_inc;
  // Count reached the guard limit
  assign limit_hit = (wait_d >= FAIR_LIMIT);

  // Guard state follows the wait count
  always_comb begin
    state_d = bank_arb_pkg::ARB_IDLE;
    case (state_q)
      bank_arb_pkg::ARB_IDLE: begin
        if (!dma_pending) begin
          state_d = bank_arb_pkg::ARB_IDLE;
        end else if (limit_hit) begin
          state_d = bank_arb_pkg::ARB_TURN;
        end else begin
          state_d = bank_arb_pkg::ARB_WAIT;
        end
      end
      bank_arb_pkg::ARB_WAIT: begin
        if (!dma_pending) begin
          state_d = bank_arb_pkg::ARB_IDLE;
        end else if (limit_hit) begin
          state_d = bank_arb_pkg::ARB_TURN;
        end else begin
          state_d = bank_arb_pkg::ARB_WAIT;
        end
      end
      bank_arb_pkg::ARB_TURN: begin
        if (!dma_pending) begin
          state_d = bank_arb_pkg::ARB_IDLE;
        end else begin
          state_d = bank_arb_pkg::ARB_TURN;
        end
      end
      default: begin
        state_d = bank_arb_pkg::ARB_IDLE;
      end
    endcase
  end

  // Wait count and guard state, cleared by reset
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q  <= `WAIT_RESET;
      state_q <= bank_arb_pkg::ARB_IDLE;
    end else begin
      wait_q  <= wait_d; // RULE12
      state_q <= state_d;
    end
  end
endmodule

// *** sim/arb_sva.sv ***
// Checker for bank arbiter grants
`timescale 1ns/1ps
module arb_sva (
  // Clock, reset and guard enable
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   fair_en,
  // Requests
  input  wire bank_arb_pkg::ram_req_t store_a,
  input  wire bank_arb_pkg::ram_req_t store_b,
  input  wire bank_arb_pkg::ram_req_t load_req,
  input  wire bank_arb_pkg::ram_req_t dma_req,
  // Grants
  input  wire logic                   store_a_gnt,
  input  wire logic                   store_b_gnt,
  input  wire logic                   load_gnt,
  input  wire logic                   dma_gnt,
  input  wire logic                   dma_pending
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Store ports aimed at the engine's bank, and stores split over banks
  wire clash   = store_a.valid && store_a.addr[4:3] == dma_req.addr[4:3];
  wire clash_b = store_b.valid && store_b.addr[4:3] == dma_req.addr[4:3];
  wire split   = store_a.valid && store_b.valid && store_a.addr[4:3] != store_b.addr[4:3];
  // Engine held off four cycles with the guard on, then still asking
  sequence starved_s;
    (dma_pending && fair_en)[*4];
  endsequence
  sequence turn_s;
    fair_en && dma_req.valid;
  endsequence
  core_wins_a: assert property (
    dma_req.valid && clash && !store_b.valid && !load_req.valid && !fair_en
    |-> store_a_gnt && !dma_gnt) else $error("core lost clash");
  diff_bank_a: assert property (
    dma_req.valid && store_a.valid && !clash |-> dma_gnt && store_a_gnt)
    else $error("split banks blocked");
  load_gap_a: assert property (
    dma_req.valid && load_req.valid |-> dma_gnt) else $error("no gap");
  pend_hold_a: assert property (
    dma_req.valid && !dma_gnt |-> dma_pending) else $error("lost");
  both_win_a: assert property (
    dma_req.valid && clash && clash_b && !load_req.valid && !fair_en
    |-> store_a_gnt && store_b_gnt && !dma_gnt) else $error("store pair lost clash");
  two_store_a: assert property (
    dma_req.valid && split |-> dma_gnt) else $error("split stores locked engine");
  bank_excl_a: assert property (
    !(clash && store_a_gnt && dma_gnt)) else $error("bank granted twice");
  fair_turn_a: assert property (
    starved_s ##1 turn_s |-> dma_gnt) else $error("guard gave no turn");
endmodule
bind l2_bank_conflict_arbiter arb_sva u_sva (
  .core_clk    (core_clk),
  .rst_n       (rst_n),
  .fair_en     (fair_en),
  .store_a     (store_a),
  .store_b     (store_b),
  .load_req    (load_req),
  .dma_req     (dma_req),
  .store_a_gnt (store_a_gnt),
  .store_b_gnt (store_b_gnt),
  .load_gnt    (load_gnt),
  .dma_gnt     (dma_gnt),
  .dma_pending (dma_pending)
);

// *** sim/dma_model.sv ***
// Transfer engine model holding its request until granted
`timescale 1ns/1ps
module dma_model (
  // Clock
  input  wire logic                   core_clk,
  // Bench control and arbiter answer
  input  wire logic                   go,
  input  wire logic                   dma_gnt,
  input  wire logic [31:0]            a,
  // Request to the arbiter
  output bank_arb_pkg::ram_req_t      dma_req
);
  initial dma_req = '0;
  // Hold until granted, then drop valid and scramble the idle address
  always @(posedge core_clk) begin
    if (go) begin
      dma_req.valid <= 1'b1;
      dma_req.addr  <= a;
    end else if (dma_gnt) begin
      dma_req.valid <= 1'b0;
      dma_req.addr  <= ~dma_req.addr;
    end
  end
endmodule

// *** sim/l2_bank_conflict_arbiter_tb.sv ***
// Bench for the bank arbiter
`timescale 1ns/1ps
module l2_bank_conflict_arbiter_tb;
  logic core_clk = 0, rst_n = 0, fair_en = 0, go = 0;
  logic store_a_gnt, store_b_gnt, load_gnt, dma_gnt, dma_pending;
  logic [31:0] a = 32'h0;
  bank_arb_pkg::ram_req_t store_a = '0, store_b = '0, load_req = '0, dma_req;
  int n_fail = 0, n_tests = 0, cyc = 0;
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) if (++cyc > 500) begin n_fail++; close_out(); end
  l2_bank_conflict_arbiter u_dut (.*);
  dma_model u_dma (.*);
  task automatic chk(logic ok);
    n_tests++;
    if (ok !== 1'b1) begin n_fail++; $display("[ERR] %0t grant mismatch", $time); end
  endtask
  // Engine waits on a store clash, then wins when the store moves
  task automatic t_clash;
    @(posedge core_clk) #1 a = 32'h20;
    go = 1;
    store_a = '{1'b1, 32'h0};
    @(posedge core_clk) #1 go = 0;
    @(negedge core_clk);
    chk(store_a_gnt === 1'b1 && dma_gnt === 1'b0 && dma_pending === 1'b1);
    @(posedge core_clk) #1 store_a.addr = 32'h8;
    @(negedge core_clk);
    chk(dma_gnt === 1'b1 && store_a_gnt === 1'b1 && dma_pending === 1'b0);
    $display("clash test done");
  endtask
  // A load beside a clashing store opens the gap
  task automatic t_load;
    @(posedge core_clk) #1 store_a = '{1'b1, 32'h0};
    load_req = '{1'b1, 32'h18};
    a = 32'h40;
    go = 1;
    @(posedge core_clk) #1 go = 0;
    @(negedge core_clk);
    chk(dma_gnt === 1'b1 && load_gnt === 1'b1 && store_a_gnt === 1'b0);
    @(posedge core_clk) #1 store_a = '0;
    load_req = '0;
    $display("load gap test done");
  endtask
  // Two stores on one bank hold the engine, split stores let it in
  task automatic t_pair;
    @(posedge core_clk) #1 a = 32'h20;
    go = 1;
    store_a = '{1'b1, 32'h0};
    store_b = '{1'b1, 32'h20};
    @(posedge core_clk) #1 go = 0;
    @(negedge core_clk);
    chk(dma_pending === 1'b1 && store_a_gnt === 1'b1 && store_b_gnt === 1'b1);
    @(posedge core_clk) #1 store_b.addr = 32'h10;
    @(negedge core_clk);
    chk(dma_gnt === 1'b1 && store_a_gnt === 1'b0 && store_b_gnt === 1'b1);
    $display("store pair test done");
  endtask
  // Guard gives the engine a turn after four lost cycles
  task automatic t_fair;
    @(posedge core_clk) #1 fair_en = 1;
    go = 1;
    a = 32'h20;
    store_a = '{1'b1, 32'h0};
    store_b = '0;
    @(posedge core_clk) #1 go = 0;
    repeat (4) begin
      @(negedge core_clk);
      chk(dma_pending === 1'b1 && dma_gnt === 1'b0);
      @(posedge core_clk);
    end
    @(negedge core_clk);
    chk(dma_gnt === 1'b1 && store_a_gnt === 1'b0);
    @(posedge core_clk) #1 fair_en = 0;
    store_a = '0;
    $display("guard test done");
  endtask
  task automatic close_out;
    $display("tests %0d fails %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    #1 rst_n = 1;
    t_clash();
    t_load();
    t_pair();
    t_fair();
    close_out();
  end
endmodule
